// ---- logic/pdt_top.sv ----
// Decimator, trigger and timing filter with APB register access
//
// Overview of operation
// - Energy stream rate divided by 1, 2, 4 or 8 as selected.
// - Each decimated sample is the mean of a group of inputs.
// - Decimation only touches the energy branch samples.
// - Timing filter, hold-off and record length run at full rate.
// - Rescale mode: decimation only scales record length, filters untouched.
// - The polarity-corrected stream feeds timing and energy paths.
// - Detect each pulse, pulse a trigger and stamp its time.
// - Bipolar second-derivative signal; its zero crossing gives the stamp.
// - Moving-average smoother keeps spikes from triggering.
// - Derivative removes baseline so drift leaves the threshold alone.
// - Arm on threshold crossing, trigger on next zero crossing.
// - By default interpolate the crossing between neighbour samples.
// - Smoothing setting picks the moving average length.
// - Rise time setting picks the delay to the filter peak.
// - Samples are kept at full 14-bit resolution throughout.
// - Hold-off after each trigger inhibits further triggers.
`timescale 1ns/100ps
module pdt_top
  import pdt_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             adc_valid,
  input  wire logic [ADC_W-1:0] adc_data,
  output logic                  trig_o,
  output logic [TS_W-1:0]       tstamp_o,
  output logic [FRAC_W-1:0]     tfrac_o,
  output logic                  energy_valid_o,
  output logic [ADC_W-1:0]      energy_data_o,
  output logic [18:0]           record_len_o
);

  // ----------------------------------------------------------------
  // Fraction of a sample period at which the line crosses zero
  // ----------------------------------------------------------------
  function automatic logic [FRAC_W-1:0] zc_frac(
    input logic [BIP_W:0] num,
    input logic [BIP_W:0] den
  );
    logic [BIP_W+1:0] r;
    logic [FRAC_W-1:0] q;
    r = {1'b0, num};
    q = '0;
    for (int i = FRAC_W - 1; i >= 0; i--) begin
      r = r << 1;
      if (r >= {1'b0, den}) begin
        r    = r - {1'b0, den};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [5:0]        ctrl_r;
  logic [15:0]       thresh_r;
  logic [2:0]        smooth_r;
  logic [5:0]        rise_r;
  logic [15:0]       holdoff_r;
  logic [15:0]       reclen_r;
  logic [15:0]       trig_cnt_r;
  pdt_trig_t         state_r;
  logic              wr_en;
  logic              addr_ok;
  logic [31:0]       rd_val;

  // Two-cycle access: pready rises one cycle into the access phase
  assign wr_en = psel & penable & pready & pwrite & addr_ok;

  // Address decode and read mux
  always_comb begin
    addr_ok = 1'b1;
    rd_val  = '0;
    unique case (paddr)
      OFS_CTRL:    rd_val = {26'h0, ctrl_r};
      OFS_THRESH:  rd_val = {16'h0, thresh_r};
      OFS_SMOOTH:  rd_val = {29'h0, smooth_r};
      OFS_RISE:    rd_val = {26'h0, rise_r};
      OFS_HOLDOFF: rd_val = {16'h0, holdoff_r};
      OFS_RECLEN:  rd_val = {16'h0, reclen_r};
      OFS_STATUS:  rd_val = {trig_cnt_r, 14'h0,
                             state_r == PDT_HOLD, state_r == PDT_ARMED};
      OFS_TSTAMP:  rd_val = tstamp_o;
      OFS_TFRAC:   rd_val = {28'h0, tfrac_o};
      default:     addr_ok = 1'b0;
    endcase
  end

  // APB answer: data and error flag held with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & ~pwrite & addr_ok) ? rd_val : 32'h0;
      pslverr <= psel & penable & ~pready & ~addr_ok;
    end
  end

  // Writable settings; out-of-range smoothing is clamped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= CTRL_RST;
      thresh_r  <= THRESH_RST;
      smooth_r  <= SMOOTH_RST;
      rise_r    <= RISE_RST;
      holdoff_r <= HOLDOFF_RST;
      reclen_r  <= RECLEN_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL:    ctrl_r    <= pwdata[5:0];
        OFS_THRESH:  thresh_r  <= pwdata[15:0];
        OFS_SMOOTH:  smooth_r  <= (pwdata[2:0] > SMOOTH_MAX) ?
                                  SMOOTH_MAX : pwdata[2:0];
        OFS_RISE:    rise_r    <= (pwdata[5:0] == 6'h0) ?
                                  6'h1 : pwdata[5:0];
        OFS_HOLDOFF: holdoff_r <= pwdata[15:0];
        OFS_RECLEN:  reclen_r  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input stage and energy branch
  // ----------------------------------------------------------------
  logic [ADC_W-1:0] x;
  logic [1:0]       dec_sel;

  // Polarity-corrected stream shared by both branches
  assign x = ctrl_r[CTRL_INV] ? ~adc_data : adc_data;
  // Rescale mode keeps the energy branch at full rate
  assign dec_sel = ctrl_r[CTRL_RESC] ? 2'h0 :
                   ctrl_r[CTRL_DEC_LO+1:CTRL_DEC_LO];

  pdt_decim u_decim (
    .clk        (pclk),
    .rst_n      (presetn),
    .in_valid   (adc_valid & ctrl_r[CTRL_EN]),
    .in_data    (x),
    .factor_sel (dec_sel),
    .out_valid  (energy_valid_o),
    .out_data   (energy_data_o)
  );

  // Record length in full-rate samples; only rescale mode scales it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      record_len_o <= '0;
    end else if (ctrl_r[CTRL_RESC]) begin
      record_len_o <= {3'h0, reclen_r}
                      << ctrl_r[CTRL_DEC_LO+1:CTRL_DEC_LO];
    end else begin
      record_len_o <= {3'h0, reclen_r};
    end
  end

  // ----------------------------------------------------------------
  // Trigger and timing filter, always at the full sample rate
  // ----------------------------------------------------------------
  logic [ADC_W-1:0]        raw_ring [RING_N];
  logic [ADC_W-1:0]        sm_ring  [RING_N];
  logic signed [BIP_W-1:0] d1_ring  [RING_N];
  logic [RING_AW-1:0]      wp_r;
  logic [ADC_W+5:0]        sum_r;
  logic [ADC_W+5:0]        sum_nxt;
  logic [ADC_W-1:0]        sm;
  logic signed [BIP_W-1:0] d1;
  logic signed [BIP_W-1:0] bip;
  logic signed [BIP_W-1:0] bip_r;
  logic [RING_AW-1:0]      old_smooth_idx;
  logic [RING_AW-1:0]      old_rise_idx;

  assign old_smooth_idx = wp_r - (6'h1 << smooth_r);
  assign old_rise_idx   = wp_r - rise_r;

  // Running sum over the window; stale rings hold zero after reset
  assign sum_nxt = sum_r + {6'h0, x}
                   - {6'h0, raw_ring[old_smooth_idx]};
  assign sm      = ADC_W'(sum_nxt >> smooth_r);
  // Difference over the rise time drops the baseline
  assign d1  = $signed({2'b00, sm})
             - $signed({2'b00, sm_ring[old_rise_idx]});
  // Second difference gives the bipolar shape
  assign bip = d1 - d1_ring[old_rise_idx];

  // History rings; a smoothing change under live data leaves a sum offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      sum_r <= '0;
      bip_r <= '0;
      for (int i = 0; i < RING_N; i++) begin
        raw_ring[i] <= '0;
        sm_ring[i]  <= '0;
        d1_ring[i]  <= '0;
      end
    end else if (adc_valid) begin
      raw_ring[wp_r] <= x;
      sm_ring[wp_r]  <= sm;
      d1_ring[wp_r]  <= d1;
      sum_r          <= sum_nxt;
      bip_r          <= bip;
      wp_r           <= wp_r + 6'h1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger logic
  // ----------------------------------------------------------------
  logic [TS_W-1:0] sample_cnt_r;
  logic [15:0]     hold_cnt_r;
  logic            above_r;
  logic            above;
  logic            fresh;
  logic            zero_x;
  logic [BIP_W:0]  zc_num;
  logic [BIP_W:0]  zc_den;

  assign above  = bip >= $signed(thresh_r);
  assign fresh  = above & ~above_r;
  assign zero_x = (bip_r > 0) && (bip <= 0);
  assign zc_num = {1'b0, bip_r};
  assign zc_den = 17'({bip_r[BIP_W-1], bip_r} - {bip[BIP_W-1], bip});

  // Sample counter used as time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt_r <= '0;
      above_r      <= 1'b0;
    end else if (adc_valid) begin
      sample_cnt_r <= sample_cnt_r + 32'h1;
      above_r      <= above;
    end
  end

  // Arm, fire at zero crossing, then sit out the hold-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= PDT_IDLE;
      hold_cnt_r <= '0;
      trig_o     <= 1'b0;
      tstamp_o   <= '0;
      tfrac_o    <= '0;
      trig_cnt_r <= '0;
    end else begin
      trig_o <= 1'b0;
      if (!ctrl_r[CTRL_EN]) begin
        state_r <= PDT_IDLE;
      end else if (adc_valid) begin
        unique case (state_r)
          PDT_IDLE: begin
            if (fresh) begin
              state_r <= PDT_ARMED;
            end
          end
          PDT_ARMED: begin
            if (zero_x) begin
              trig_o     <= 1'b1;
              tstamp_o   <= sample_cnt_r - 32'h1;
              tfrac_o    <= ctrl_r[CTRL_INTERP] ?
                            zc_frac(zc_num, zc_den) : 4'h0;
              trig_cnt_r <= trig_cnt_r + 16'h1;
              hold_cnt_r <= holdoff_r;
              state_r    <= (holdoff_r == 16'h0) ?
                            PDT_IDLE : PDT_HOLD;
            end
          end
          PDT_HOLD: begin
            // Counted in full-rate samples
            if (hold_cnt_r <= 16'h1) begin
              state_r <= PDT_IDLE;
            end
            hold_cnt_r <= hold_cnt_r - 16'h1;
          end
        endcase
      end
    end
  end

endmodule

// ---- logic/pdt_pkg.sv ----
// Shared constants of the pulse decimator and trigger filter block
package pdt_pkg;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int ADC_W   = 14;   // Full converter resolution
  localparam int BIP_W   = 16;   // Signed bipolar signal width
  localparam int RING_AW = 6;    // Index width of history rings
  localparam int RING_N  = 64;   // History ring depth
  localparam int TS_W    = 32;   // Time stamp counter width
  localparam int FRAC_W  = 4;    // Interpolated fraction bits

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_THRESH  = 8'h04;
  localparam logic [7:0] OFS_SMOOTH  = 8'h08;
  localparam logic [7:0] OFS_RISE    = 8'h0c;
  localparam logic [7:0] OFS_HOLDOFF = 8'h10;
  localparam logic [7:0] OFS_RECLEN  = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_TSTAMP  = 8'h1c;
  localparam logic [7:0] OFS_TFRAC   = 8'h20;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN     = 0;
  localparam int CTRL_INV    = 1;
  localparam int CTRL_DEC_LO = 2;
  localparam int CTRL_RESC   = 4;
  localparam int CTRL_INTERP = 5;
  localparam logic [5:0]  CTRL_RST    = 6'h20;   // Interpolation on
  localparam logic [15:0] THRESH_RST  = 16'h0064;
  localparam logic [2:0]  SMOOTH_RST  = 3'h2;
  localparam logic [2:0]  SMOOTH_MAX  = 3'h5;    // At most 32 samples
  localparam logic [5:0]  RISE_RST    = 6'h08;
  localparam logic [15:0] HOLDOFF_RST = 16'h0040;
  localparam logic [15:0] RECLEN_RST  = 16'h0100;

  // Trigger logic states
  typedef enum logic [1:0] {PDT_IDLE, PDT_ARMED, PDT_HOLD} pdt_trig_t;

endpackage

// ---- logic/pdt_decim.sv ----
// Averaging decimator feeding the energy branch
`timescale 1ns/100ps
module pdt_decim
  import pdt_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [ADC_W-1:0] in_data,
  input  wire logic [1:0]       factor_sel,
  output logic                  out_valid,
  output logic [ADC_W-1:0]      out_data
);

  logic [ADC_W+2:0] acc_r;
  logic [2:0]       cnt_r;
  logic [ADC_W+2:0] sum;
  logic [2:0]       last;
  logic [ADC_W+2:0] avg;

  // Group end and averaged value; shift by the log2 of the factor
  assign sum  = acc_r + {3'h0, in_data};
  assign last = 3'((4'h1 << factor_sel) - 4'h1);
  assign avg  = sum >> factor_sel;

  // ----------------------------------------------------------------
  // Accumulate a group, emit its mean, restart
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r     <= '0;
      cnt_r     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= 1'b0;
      if (in_valid) begin
        // Factor one: last is zero, so the sample passes unchanged
        if (cnt_r >= last) begin
          out_valid <= 1'b1;
          out_data  <= avg[ADC_W-1:0];
          acc_r     <= '0;
          cnt_r     <= '0;
        end else begin
          acc_r <= sum;
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  end

endmodule

// ---- verification/pdt_chk.sv ----
// Port checker for the decimator and trigger block
`timescale 1ns/100ps
module pdt_chk
  import pdt_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              adc_valid,
  input wire logic              trig_o,
  input wire logic [TS_W-1:0]   tstamp_o,
  input wire logic [FRAC_W-1:0] tfrac_o,
  input wire logic              energy_valid_o,
  input wire logic [ADC_W-1:0]  energy_data_o
);
  // --------------------------
  // Port properties
  // --------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answer comes in the second access cycle, errors carry no data
  property p_rdy;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready off slot");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  // Trigger is a short pulse, tied to a sample, outputs held between
  property p_trg;
    trig_o |=> !trig_o [*2];
  endproperty
  a_trg: assert property (p_trg) else $error("trigger too long");
  property p_tsm;
    trig_o |-> $past(adc_valid);
  endproperty
  a_tsm: assert property (p_tsm) else $error("trigger no sample");
  property p_tsh;
    !trig_o |-> $stable(tstamp_o);
  endproperty
  a_tsh: assert property (p_tsh) else $error("stamp moved");
  property p_frh;
    !trig_o |-> $stable(tfrac_o);
  endproperty
  a_frh: assert property (p_frh) else $error("fraction moved");
  // Energy word follows a taken sample and then stays put
  property p_evs;
    energy_valid_o |-> $past(adc_valid);
  endproperty
  a_evs: assert property (p_evs) else $error("energy no sample");
  property p_evh;
    !energy_valid_o |-> $stable(energy_data_o);
  endproperty
  a_evh: assert property (p_evh) else $error("energy moved");
endmodule

bind pdt_top pdt_chk pdt_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_valid(adc_valid), .trig_o(trig_o), .tstamp_o(tstamp_o),
  .tfrac_o(tfrac_o), .energy_valid_o(energy_valid_o),
  .energy_data_o(energy_data_o)
);

// ---- verification/pdt_adc_src.sv ----
// Behavioural sample source standing in for the digitiser
`timescale 1ns/100ps
module pdt_adc_src
  import pdt_pkg::*;
(
  input  wire logic        pclk,
  output logic             adc_valid,
  output logic [ADC_W-1:0] adc_data
);
  // --------------------------
  // Sample driving
  // --------------------------
  initial begin
    adc_valid = 1'b0;
    adc_data  = '0;
  end

  // Idle data is inverted so a stale word never passes for a sample
  task automatic idle();
    adc_valid <= 1'b0;
    adc_data  <= ~adc_data;
    @(posedge pclk);
  endtask

  // One sample, after an optional idle cycle to model a slow source
  task automatic send(input logic [ADC_W-1:0] d, input logic gap);
    if (gap)
      idle();
    adc_valid <= 1'b1;
    adc_data  <= d;
    @(posedge pclk);
  endtask
endmodule

// ---- verification/tb_pdt_top.sv ----
// Self-checking bench for the decimator and trigger block
`timescale 1ns/100ps
module tb_pdt_top
  import pdt_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready;
  logic              pslverr, er, adc_valid, trig_o, energy_valid_o;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd, seed;
  logic [ADC_W-1:0]  adc_data, energy_data_o;
  logic [TS_W-1:0]   tstamp_o;
  logic [FRAC_W-1:0] tfrac_o;
  logic [18:0]       record_len_o;
  int                miscompares, n_compared, n_smp, n_trig, acc, grp;
  int                en_n, model_en, st, lvl, t0, model_inv, smp, ev;
  int                expq[$];
  logic [7:0]        ofs[7] = '{OFS_CTRL, OFS_THRESH, OFS_SMOOTH,
                       OFS_RISE, OFS_HOLDOFF, OFS_RECLEN, OFS_TSTAMP};
  logic [31:0]       rv[7] = '{32'h20, 32'h64, 32'h2, 32'h8, 32'h40,
                       32'h100, 32'h0};

  // --------------------------
  // Clock, design, source
  // --------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  pdt_top pdt_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid),
    .adc_data(adc_data), .trig_o(trig_o), .tstamp_o(tstamp_o),
    .tfrac_o(tfrac_o), .energy_valid_o(energy_valid_o),
    .energy_data_o(energy_data_o), .record_len_o(record_len_o));
  pdt_adc_src pdt_adc_src_inst (
    .pclk(pclk), .adc_valid(adc_valid), .adc_data(adc_data));

  // --------------------------
  // Helpers
  // --------------------------
  function automatic void xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  task automatic check(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // A spare cycle at the end keeps psel from toggling twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and data are taken at the rising edge that shows pready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Control write; the model follows enable and the group size
  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, OFS_CTRL, v);
    model_en <= int'(v[CTRL_EN]);
    model_inv <= int'(v[CTRL_INV]);
    en_n <= v[CTRL_RESC] ? 1 : 1 << v[CTRL_DEC_LO +: 2];
  endtask
  task automatic burst(input int v, input int n);
    repeat (n) pdt_adc_src_inst.send(v[ADC_W-1:0], 1'b0);
    pdt_adc_src_inst.idle();
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reference model: group means, sample index, trigger count
  always @(posedge pclk) begin
    if (energy_valid_o === 1'b1) begin
      ev = expq.size() ? expq.pop_front() : -1;
      check("energy", energy_data_o, ev);
    end
    if (trig_o === 1'b1)
      n_trig++;
    if (adc_valid === 1'b1) begin
      n_smp++;
      smp = model_inv ? (1 << ADC_W) - 1 - int'(adc_data) : int'(adc_data);
      acc += model_en ? smp : 0;
      grp += model_en;
      if (grp == en_n) begin
        expq.push_back(acc / en_n);
        acc = 0;
        grp = 0;
      end
    end
  end

  // --------------------------
  // Test sequence
  // --------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    seed = 32'd4942;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      check("reset value", rd, rv[i]);
    end
    apb(1'b1, OFS_TSTAMP, 32'hffffffff);
    apb(1'b0, OFS_TSTAMP, 32'h0);
    check("read-only", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    $display("register test done");
    // Every factor on random samples with random stalls, odd ones inverted
    for (int s = 0; s < 4; s++) begin
      ctrl(32'h20);
      ctrl(32'h21 | (s << CTRL_DEC_LO) | ((s & 1) << CTRL_INV));
      repeat (24) begin
        xs();
        pdt_adc_src_inst.send(seed[ADC_W-1:0], seed[20]);
      end
      pdt_adc_src_inst.idle();
      repeat (3) @(negedge pclk);
      check("groups left", expq.size(), 0);
      @(posedge pclk);
    end
    ctrl(32'h20);
    ctrl(32'h39);
    burst(3000, 8);
    repeat (3) @(negedge pclk);
    check("scaled length", record_len_o, 32'h400);
    check("groups left", expq.size(), 0);
    @(posedge pclk);
    ctrl(32'h28);
    repeat (3) @(negedge pclk);
    check("record length", record_len_o, 32'h100);
    @(posedge pclk);
    $display("decimation test done");
    // Steps: one trigger each, a second step inside hold-off is refused
    ctrl(32'h20);
    // Zeros first, so the running sum holds no offset across the change
    burst(0, 4);
    apb(1'b1, OFS_SMOOTH, 32'h0);
    apb(1'b1, OFS_RISE, 32'h4);
    apb(1'b1, OFS_HOLDOFF, 32'h10);
    lvl = 1000;
    burst(lvl, 70);
    ctrl(32'h21);
    t0 = n_trig;
    for (int k = 1; k < 4; k++) begin
      st = n_smp;
      burst(lvl + 2000, 6);
      burst(lvl + 4000, 40);
      lvl += 4000;
      repeat (2) @(negedge pclk);
      check("triggers", n_trig, t0 + k);
      check("stamp", tstamp_o, st + 3);
      check("fraction", tfrac_o, 32'h8);
      @(posedge pclk);
    end
    // Falling step, interpolation off: fires at the later crossing
    ctrl(32'h01);
    st = n_smp;
    burst(1000, 40);
    repeat (2) @(negedge pclk);
    check("triggers", n_trig, t0 + 4);
    check("stamp", tstamp_o, st + 7);
    check("fraction", tfrac_o, 32'h0);
    @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("count", {16'h0, rd[31:16]}, n_trig);
    check("state", {30'h0, rd[1:0]}, 32'h0);
    $display("trigger test done");
    stop_test();
  end

  // A hang counts as a mismatch
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
endmodule
